// >>> logic/aso_serial_out.sv
// Converter serial output: framing, lanes, patterns and control registers
`timescale 1ns/1ps
`default_nettype none
module aso_serial_out #(
  parameter int STOP_CNT = aso_pkg::STOP_CYCLES
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         sample_clock_pos,
  input  wire logic         sample_sync_in,
  input  wire logic         reset_pin_n,
  input  wire logic         powerdown_pin_n,
  input  wire logic [143:0] conv_results,
  input  wire logic         cfg_wr,
  input  wire logic         cfg_rd,
  input  wire logic [7:0]   cfg_addr,
  input  wire logic [15:0]  cfg_wdata,
  output logic      [15:0]  cfg_rdata,
  output logic      [3:0]   data_lanes,
  output logic              bit_clock_out,
  output logic              frame_clock_out,
  output logic              powered_down,
  output logic              internal_ref_off
);
  import aso_pkg::*;

  typedef struct packed {
    logic [2:0]  sck;
    logic [1:0]  syn;
    logic [1:0]  rpn;
    logic [1:0]  ppn;
    logic        sync_hit;
    logic [7:0]  idle;
    logic        stopped;
    logic [1:0]  seq;
    logic        fclk;
    logic        bclk;
    logic        phase;
    logic        pdo;
    aso_tx_e     tx;
    logic [7:0]  left;
    logic [3:0][LBITS_2-1:0] sr;
    logic [3:0]  lane;
    logic [15:0] bank, init1, fmt, pca, pcb, ta0, ta1, tb0, tb1, pd, ifc, init2, rdata;
    logic [17:0] ra, rb;
    logic        alt;
  } aso_state_s;

  aso_state_s s_reg, s_next;
  logic [CHANNELS-1:0][SLOT_BITS-1:0] slot;
  logic [3:0][LBITS_2-1:0] ld;
  logic rise, fall, pdn, fstart, two, ddr, wr_b0, wr_b1, soft_rst;
  logic [1:0] seq_n;

  function automatic logic [17:0] ramp_step(input logic [15:0] ctl);
    return {10'b0, ctl[PAT_INC +: PAT_INC_W]} + 18'd1;
  endfunction

  function automatic logic [17:0] conv_fmt(input logic [17:0] c, input logic [15:0] f);
    logic [17:0] v;
    v = f[FMT_TWOS] ? {~c[17], c[16:0]} : c;
    if (f[FMT_RAND]) begin
      v[17:1] = v[17:1] ^ {17{v[0]}};
    end
    return v;
  endfunction

  function automatic logic [17:0] slot_val(input logic [15:0] ctl, input logic [15:0] t0,
                                           input logic [15:0] t1, input logic [17:0] ramp,
                                           input logic alt, input logic [1:0] k,
                                           input logic [17:0] conv);
    if (!ctl[PAT_EN]) begin
      return conv;
    end
    case (aso_pat_e'(ctl[PAT_MODE +: 2]))
      PAT_RAMP: return ramp + 18'(ramp_step(ctl) * {16'b0, k});
      PAT_ALT:  return alt ? {t1, 2'b00} : {t0, 2'b00};
      default:  return {t0, 2'b00};
    endcase
  endfunction

  always_comb begin
    rise  = s_reg.sck[1] & ~s_reg.sck[2];
    fall  = ~s_reg.sck[1] & s_reg.sck[2];
    two   = s_reg.ifc[IF_LANES];
    ddr   = ~s_reg.ifc[IF_RATE];
    seq_n = s_reg.sync_hit ? SEQ_FIRST : s_reg.seq + 2'd1;
    pdn   = s_reg.stopped | ~s_reg.ppn[1] | ~s_reg.rpn[1]
          | (s_reg.pd[PD_LO +: 2] == PD_ALL);
    fstart = rise & ~pdn & (seq_n == SEQ_FIRST);
    wr_b0 = cfg_wr;
    wr_b1 = cfg_wr & (s_reg.bank == BANK1_CODE);
    soft_rst = wr_b0 & (cfg_addr == A_RESET) & cfg_wdata[RST_BIT];
    for (int i = 0; i < CHANNELS; i++) begin
      if (i < GROUP_CH) begin
        slot[i] = {slot_val(s_reg.pca, s_reg.ta0, s_reg.ta1, s_reg.ra, s_reg.alt, 2'(i),
                            conv_fmt(conv_results[i*RES_BITS +: RES_BITS], s_reg.fmt)),
                   {PAD_BITS{1'b0}}};
      end else begin
        slot[i] = {slot_val(s_reg.pcb, s_reg.tb0, s_reg.tb1, s_reg.rb, s_reg.alt, 2'(i),
                            conv_fmt(conv_results[i*RES_BITS +: RES_BITS], s_reg.fmt)),
                   {PAD_BITS{1'b0}}};
      end
    end
    ld = '0;
    if (two) begin
      ld[3] = {slot[0], slot[1], slot[2], slot[3]};
      ld[1] = {slot[4], slot[5], slot[6], slot[7]};
    end else begin
      for (int j = 0; j < LANES_MAX; j++) begin
        ld[3-j] = {slot[2*j], slot[2*j+1], {LBITS_4{1'b0}}};
      end
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.sck = {s_reg.sck[1:0], sample_clock_pos};
    s_next.syn = {s_reg.syn[0], sample_sync_in};
    s_next.rpn = {s_reg.rpn[0], reset_pin_n};
    s_next.ppn = {s_reg.ppn[0], powerdown_pin_n};
    // Any sampling clock edge proves the clock is alive
    if (rise | fall) begin
      s_next.idle = '0;
      s_next.stopped = 1'b0;
    end else if (s_reg.idle == 8'(STOP_CNT - 1)) begin
      s_next.stopped = 1'b1;
    end else begin
      s_next.idle = s_reg.idle + 8'd1;
    end
    if (fall) begin
      s_next.sync_hit = s_reg.syn[1];
    end
    if (rise) begin
      s_next.seq = seq_n;
      s_next.sync_hit = 1'b0;
      // Only a frame start may raise it, so leaving power-down mid-frame gives no early edge
      s_next.fclk = fstart | (s_reg.fclk & (seq_n < SEQ_HALF) & ~pdn);
    end
    s_next.pdo = pdn;
    if (pdn) begin
      s_next.tx = TX_IDLE;
      s_next.lane = '0;
      s_next.bclk = 1'b0;
      s_next.fclk = 1'b0;
    end else if (fstart) begin
      for (int j = 0; j < LANES_MAX; j++) begin
        s_next.lane[j] = ld[j][LBITS_2-1];
        s_next.sr[j] = ld[j] << 1;
      end
      s_next.left = two ? 8'(LBITS_2 - 1) : 8'(LBITS_4 - 1);
      s_next.tx = TX_SEND;
      s_next.bclk = 1'b0;
      s_next.phase = 1'b0;
      s_next.alt = ~s_reg.alt;
      if (s_reg.pca[PAT_EN] && s_reg.pca[PAT_MODE +: 2] == PAT_RAMP) begin
        s_next.ra = s_reg.ra + 18'(ramp_step(s_reg.pca) * 18'd4);
      end
      if (s_reg.pcb[PAT_EN] && s_reg.pcb[PAT_MODE +: 2] == PAT_RAMP) begin
        s_next.rb = s_reg.rb + 18'(ramp_step(s_reg.pcb) * 18'd4);
      end
    end else if (s_reg.tx == TX_SEND) begin
      // Double rate moves a bit on every clock edge, single rate on falling ones
      s_next.bclk = ~s_reg.bclk;
      s_next.phase = ~s_reg.phase;
      if (ddr || s_reg.phase) begin
        if (s_reg.left == 8'd0) begin
          s_next.tx = TX_IDLE;
          s_next.lane = '0;
          s_next.bclk = 1'b0;
        end else begin
          for (int j = 0; j < LANES_MAX; j++) begin
            s_next.lane[j] = s_reg.sr[j][LBITS_2-1];
            s_next.sr[j] = s_reg.sr[j] << 1;
          end
          s_next.left = s_reg.left - 8'd1;
        end
      end
    end
    s_next.rdata = '0;
    if (cfg_rd) begin
      case (cfg_addr)
        A_BANK:  s_next.rdata = s_reg.bank;
        A_INIT1: s_next.rdata = s_reg.init1;
        default: s_next.rdata = '0;
      endcase
      if (s_reg.bank == BANK1_CODE) begin
        case (cfg_addr)
          A_FMT:   s_next.rdata = s_reg.fmt;
          A_PCA:   s_next.rdata = s_reg.pca;
          A_TA0:   s_next.rdata = s_reg.ta0;
          A_TA1:   s_next.rdata = s_reg.ta1;
          A_PCB:   s_next.rdata = s_reg.pcb;
          A_TB0:   s_next.rdata = s_reg.tb0;
          A_TB1:   s_next.rdata = s_reg.tb1;
          A_PD:    s_next.rdata = s_reg.pd;
          A_IF:    s_next.rdata = s_reg.ifc;
          A_INIT2: s_next.rdata = s_reg.init2;
          default: s_next.rdata = s_next.rdata;
        endcase
      end
    end
    if (wr_b0 && cfg_addr == A_BANK) s_next.bank = cfg_wdata;
    if (wr_b0 && cfg_addr == A_INIT1) s_next.init1 = cfg_wdata;
    if (wr_b1) begin
      case (cfg_addr)
        A_FMT:   s_next.fmt = cfg_wdata;
        A_PCA:   s_next.pca = cfg_wdata;
        A_TA0:   s_next.ta0 = cfg_wdata;
        A_TA1:   s_next.ta1 = cfg_wdata;
        A_PCB:   s_next.pcb = cfg_wdata;
        A_TB0:   s_next.tb0 = cfg_wdata;
        A_TB1:   s_next.tb1 = cfg_wdata;
        A_PD:    s_next.pd = cfg_wdata;
        A_IF:    s_next.ifc = cfg_wdata;
        A_INIT2: s_next.init2 = cfg_wdata;
        default: s_next.init2 = s_next.init2;
      endcase
    end
    // Pin or soft reset restores defaults; power-down alone keeps them
    if (~s_reg.rpn[1] | soft_rst) begin
      {s_next.bank, s_next.init1, s_next.fmt, s_next.pca, s_next.pcb, s_next.ta0, s_next.ta1,
       s_next.tb0, s_next.tb1, s_next.pd, s_next.ifc, s_next.init2} = {12{REG_DEFAULT}};
      s_next.ra = '0;
      s_next.rb = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.stopped <= 1'b1;
      s_reg.pdo <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cfg_rdata        = s_reg.rdata;
  assign data_lanes       = s_reg.lane;
  assign bit_clock_out    = s_reg.bclk;
  assign frame_clock_out  = s_reg.fclk;
  assign powered_down     = s_reg.pdo;
  assign internal_ref_off = s_reg.ifc[IF_REFOFF];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_pd_quiet: assert property (pdn |=> !bit_clock_out && data_lanes == 4'h0)
    else $error("lanes active while powered down");
  a_stop_detect: assert property (s_reg.idle == 8'(STOP_CNT - 1) && !rise && !fall
                                  |=> ##1 powered_down)
    else $error("stopped sampling clock not detected");
  a_sync_capture: assert property (fall |=> s_reg.sync_hit == $past(s_reg.syn[1]))
    else $error("sync not captured on falling edge");
  a_sync_align: assert property (rise && s_reg.sync_hit |=> s_reg.seq == SEQ_FIRST)
    else $error("sync did not clear sequencer");
  a_frame_edge: assert property ($rose(frame_clock_out) |-> s_reg.seq == SEQ_FIRST
                                 && s_reg.tx == TX_SEND)
    else $error("frame clock rise not at channel one");
  // The load shifts once, so the first slot's tail sits one place above where it was loaded
  a_slot_pad: assert property (fstart |=> s_reg.sr[3][LBITS_2-RES_BITS:LBITS_2-SLOT_BITS+1] == '0)
    else $error("slot tail bits not zero");
  a_two_lane: assert property (fstart && two |=> data_lanes[2] == 1'b0
                               && data_lanes[0] == 1'b0)
    else $error("unused lane driven in two-lane mode");
  a_burst_len: assert property (fstart && !two |=> s_reg.left == 8'(LBITS_4 - 1))
    else $error("wrong bits per lane");
  a_pd_field: assert property (wr_b1 && cfg_addr == A_PD && cfg_wdata[PD_LO +: 2] == PD_ALL
                               |=> ##1 powered_down)
    else $error("power-down field ignored");
  a_soft_reset: assert property (soft_rst |=> s_reg.ifc == REG_DEFAULT
                                 && s_reg.pca == REG_DEFAULT)
    else $error("soft reset kept register values");

  c_frame: cover property (fstart ##1 s_reg.tx == TX_SEND);
  c_sync: cover property (rise && s_reg.sync_hit);
  c_ramp: cover property (fstart && s_reg.pca[PAT_EN] && s_reg.pca[PAT_MODE +: 2] == PAT_RAMP);
  c_sdr_two: cover property (fstart && two && !ddr);
endmodule
`default_nettype wire

// >>> common/aso_pkg.sv
// Shared constants for the converter serial output block
package aso_pkg;
  // Configuration addresses (bank 0 unique, the rest in bank 1)
  localparam logic [7:0]  A_RESET = 8'h00;
  localparam logic [7:0]  A_BANK  = 8'h03;
  localparam logic [7:0]  A_INIT1 = 8'h04;
  localparam logic [7:0]  A_FMT   = 8'h0D;
  localparam logic [7:0]  A_PCA   = 8'h13;
  localparam logic [7:0]  A_TA0   = 8'h14;
  localparam logic [7:0]  A_TA1   = 8'h15;
  localparam logic [7:0]  A_PCB   = 8'h18;
  localparam logic [7:0]  A_TB0   = 8'h19;
  localparam logic [7:0]  A_TB1   = 8'h1A;
  localparam logic [7:0]  A_PD    = 8'hC0;
  localparam logic [7:0]  A_IF    = 8'hC1;
  localparam logic [7:0]  A_INIT2 = 8'hF6;
  localparam logic [15:0] BANK1_CODE  = 16'h0002;
  localparam logic [15:0] REG_DEFAULT = 16'h0000;
  // Field positions
  localparam int RST_BIT  = 0;
  localparam int FMT_TWOS = 0;
  localparam int FMT_RAND = 1;
  localparam int PAT_EN   = 15;
  localparam int PAT_MODE = 12;
  localparam int PAT_INC  = 0;
  localparam int PAT_INC_W = 8;
  localparam int PD_LO    = 8;
  localparam logic [1:0] PD_ALL = 2'b11;
  localparam int IF_RATE  = 0;
  localparam int IF_LANES = 1;
  localparam int IF_REFOFF = 2;
  // Frame geometry
  localparam int RES_BITS  = 18;
  localparam int SLOT_BITS = 24;
  localparam int PAD_BITS  = SLOT_BITS - RES_BITS;
  localparam int CHANNELS  = 8;
  localparam int GROUP_CH  = 4;
  localparam int LANES_MAX = 4;
  localparam int LBITS_4 = SLOT_BITS * CHANNELS / 4;
  localparam int LBITS_2 = SLOT_BITS * CHANNELS / 2;
  localparam logic [1:0] SEQ_FIRST = 2'b00;
  localparam logic [1:0] SEQ_HALF  = 2'b10;
  // Sampling clock watchdog
  localparam int MCLK_NS     = 100;
  localparam int STOP_TIME_NS = 2000;
  localparam int STOP_CYCLES = (STOP_TIME_NS + MCLK_NS - 1) / MCLK_NS;
  typedef enum logic [1:0] {
    PAT_FIX0 = 2'b00,
    PAT_FIX1 = 2'b01,
    PAT_RAMP = 2'b10,
    PAT_ALT  = 2'b11
  } aso_pat_e;
  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } aso_tx_e;
endpackage

// >>> verif/aso_host_rx.sv
// Host capture model for the serial lanes
`timescale 1ns/1ps
`default_nettype none
module aso_host_rx (
  input  wire logic        sdr,
  input  wire logic        two_lane,
  input  wire logic        frame_clock_out,
  input  wire logic        bit_clock_out,
  input  wire logic [3:0]  data_lanes,
  output logic      [95:0] cap [4],
  output int               frames
);
  int nb;
  initial begin
    frames = 0;
    forever begin
      @(posedge frame_clock_out);
      nb = two_lane ? 96 : 48;
      for (int i = 0; i < nb; i++) begin
        // DDR data is edge aligned, so sample 20 ns after each edge instead of on the edge
        if (sdr) @(posedge bit_clock_out);
        else if (i > 0) @(bit_clock_out);
        #20;
        for (int l = 0; l < 4; l++) cap[l] = {cap[l][94:0], data_lanes[l]};
      end
      frames++;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the converter serial output block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import aso_pkg::*;
  logic         mclk = 0, reset = 1, scp = 0, sync = 0, rst_n = 1, pd_n = 1;
  logic         sc_run = 0, cfg_wr = 0, cfg_rd = 0, sdr = 0, two = 0;
  logic [143:0] conv = '0;
  logic [7:0]   addr = '0;
  logic [15:0]  wdata = '0, rdata, rd_v;
  logic [3:0]   lanes;
  logic         bclk, fclk, pdn, ref_off;
  logic [95:0]  cap [4];
  int           frames, n_fail = 0, n_compared = 0, cyc = 0;

  aso_serial_out #(.STOP_CNT(40)) u_dut (
    .mclk(mclk), .reset(reset), .sample_clock_pos(scp), .sample_sync_in(sync),
    .reset_pin_n(rst_n), .powerdown_pin_n(pd_n), .conv_results(conv), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(addr), .cfg_wdata(wdata), .cfg_rdata(rdata), .data_lanes(lanes),
    .bit_clock_out(bclk), .frame_clock_out(fclk), .powered_down(pdn), .internal_ref_off(ref_off));
  aso_host_rx u_rx (.sdr(sdr), .two_lane(two), .frame_clock_out(fclk), .bit_clock_out(bclk),
    .data_lanes(lanes), .cap(cap), .frames(frames));

  always #50 mclk = ~mclk;
  // Odd half period keeps the sampling clock out of phase with mclk
  always begin
    #2537;
    if (sc_run) scp = ~scp;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task end_sim();
    $display("n_fail=%0d n_compared=%0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [95:0] e, input logic [95:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    step(1);
    addr = a;
    wdata = d;
    cfg_wr = 1;
    step(1);
    cfg_wr = 0;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    step(1);
    addr = a;
    cfg_rd = 1;
    step(1);
    cfg_rd = 0;
    rd_v = rdata;
    chk(n, 96'(e), 96'(rd_v));
  endtask
  task wait_fr(input int n);
    int f0;
    f0 = frames;
    for (int i = 0; i < 3000 && frames < f0 + n; i++) @(posedge mclk);
    #1;
    if (frames < f0 + n) begin
      n_fail++;
      $display("[FAIL] frames expected %0d seen %0d", f0 + n, frames);
    end
  endtask
  // Mode bit 0 selects two's complement, bit 1 the randomizer
  function automatic logic [17:0] val(input int k, input logic [1:0] m);
    logic [17:0] v;
    v = 18'(k * 18'h0_8421 + 18'h1_0305);
    if (m[0]) v[17] = ~v[17];
    if (m[1]) v = v ^ {{17{v[0]}}, 1'b0};
    return v;
  endfunction
  task lanes4(input string n, input logic [1:0] m);
    for (int l = 0; l < 4; l++) begin
      chk(n, 96'({val(6 - 2 * l, m), 6'h00, val(7 - 2 * l, m), 6'h00}), 96'(cap[l][47:0]));
    end
  endtask

  task t_regs();
    wr(A_BANK, BANK1_CODE);
    rchk("if_def", A_IF, REG_DEFAULT);
    chk("ref_def", 96'(0), 96'(ref_off));
    wr(A_INIT2, 16'h0002);
    wr(A_INIT1, 16'h000B);
    wr(A_BANK, 16'h0010);
    wr(8'h12, 16'h0040);
    wr(A_PCA, 16'h8000);
    wr(8'h0A, 16'h4000);
    rchk("b2_rd", A_INIT2, 16'h0000);
    wr(A_BANK, BANK1_CODE);
    rchk("pca_b2", A_PCA, 16'h0000);
    rchk("init2", A_INIT2, 16'h0002);
    rchk("init1", A_INIT1, 16'h000B);
    rchk("unmap", 8'h55, 16'h0000);
    wr(A_IF, 16'h0004);
    rchk("if_ref", A_IF, 16'h0004);
    chk("ref_off", 96'(1), 96'(ref_off));
    wr(A_IF, 16'h0000);
  endtask
  task t_frame();
    for (int k = 0; k < 8; k++) conv[k*18 +: 18] = val(k, 2'd0);
    @(posedge scp);
    #1 sync = 1;
    @(negedge scp);
    step(6);
    sync = 0;
    wait_fr(3);
    lanes4("conv4", 2'd0);
    wr(A_FMT, 16'h0002);
    wait_fr(3);
    lanes4("rand4", 2'd2);
    wr(A_FMT, 16'h0001);
    wait_fr(3);
    lanes4("twos4", 2'd1);
    wr(A_FMT, 16'h0000);
  endtask
  task t_pat();
    logic [17:0] d;
    sdr = 1;
    two = 1;
    wr(A_IF, 16'h0003);
    wr(A_TA0, 16'h1234);
    wr(A_PCA, 16'h8000);
    wr(A_PCB, 16'hA005);
    // One extra frame lets the host drop a frame caught across the mode change
    wait_fr(4);
    for (int s = 0; s < 4; s++) begin
      chk("fix_a", 96'({16'h1234, 8'h00}), 96'(cap[3][95-24*s -: 24]));
      if (s > 0) begin
        d = cap[1][95-24*s -: 18] - cap[1][119-24*s -: 18];
        chk("ramp_b", 96'(6), 96'(d));
      end
    end
    chk("idle_l", 96'(0), cap[2] | cap[0]);
  endtask
  task t_alt();
    logic [17:0] a;
    realtime t0;
    wr(A_TA1, 16'hBEEF);
    wr(A_TB0, 16'h0F0F);
    wr(A_PCA, 16'hB000);
    wr(A_PCB, 16'h9000);
    wait_fr(3);
    a = cap[3][95 -: 18];
    wait_fr(1);
    chk("alt_a", 96'(18'h0_48D0 ^ 18'h2_FBBC), 96'(a ^ cap[3][95 -: 18]));
    chk("fix_b", 96'({16'h0F0F, 2'b00}), 96'(cap[1][95 -: 18]));
    @(posedge fclk);
    t0 = $realtime;
    @(posedge fclk);
    chk("fclk_per", 96'(1), 96'(($realtime - t0 - 20296.0) ** 2 < 22500.0));
  endtask
  task t_pd();
    wr(A_PD, 16'h0300);
    step(3);
    chk("pd_fld", 96'(7'h40), 96'({pdn, bclk, fclk, lanes}));
    rchk("pd_keep", A_PD, 16'h0300);
    wr(A_PD, 16'h0000);
    pd_n = 0;
    step(5);
    chk("pd_pin", 96'(1), 96'(pdn));
    rchk("pin_keep", A_IF, 16'h0003);
    pd_n = 1;
    rst_n = 0;
    step(5);
    chk("rst_pin", 96'(1), 96'(pdn));
    rst_n = 1;
    step(4);
    wr(A_BANK, BANK1_CODE);
    rchk("rst_def", A_IF, REG_DEFAULT);
    wr(A_IF, 16'h0001);
    wr(A_RESET, 16'h0001);
    wr(A_BANK, BANK1_CODE);
    rchk("srst_def", A_IF, REG_DEFAULT);
    sc_run = 0;
    step(60);
    chk("stop_pd", 96'(1), 96'(pdn));
    sc_run = 1;
    step(200);
    chk("resume", 96'(0), 96'(pdn));
  endtask

  initial begin
    step(16);
    reset = 0;
    chk("pd_noclk", 96'(1), 96'(pdn));
    sc_run = 1;
    step(120);
    chk("pd_run", 96'(0), 96'(pdn));
    t_regs();
    t_frame();
    t_pat();
    t_alt();
    t_pd();
    end_sim();
  end
endmodule
`default_nettype wire
